// ==== logic/sbi_slave.sv ====
`default_nettype none
module sbi_slave #(
  parameter int WAIT_CYCLES = sbi_pkg::WAIT_STATES
) (
  input  wire logic  CLK_IN,
  input  wire logic  RESETN_IN,
  sbi_if.slave       BUS,
  input  wire logic  FIFO_MODE_IN,
  output logic [9:0] REG_VIEW_OUT [sbi_pkg::NUM_REGS],
  output logic       WRITE_DONE_OUT,
  output logic [3:0] WRITE_SEL_OUT
);
  //--------------------------------------------------------------------
  // Handshake state
  //--------------------------------------------------------------------
  sbi_pkg::sbi_sl_state_t state_reg;
  sbi_pkg::sbi_sl_state_t state_next;
  logic [7:0]             wait_reg;
  logic [7:0]             wait_next;
  logic                   ack_reg;
  logic                   ack_next;
  logic                   wr_reg;
  logic                   wr_next;
  logic [3:0]             sel_reg;
  logic [3:0]             sel_next;

  //--------------------------------------------------------------------
  // Read data and register storage
  //--------------------------------------------------------------------
  logic [9:0]             rdata_reg;
  logic [9:0]             rdata_next;
  logic                   done_reg;
  logic                   done_next;
  logic [9:0]             regs_reg [sbi_pkg::NUM_REGS];
  logic [9:0]             regs_next [sbi_pkg::NUM_REGS];

  //--------------------------------------------------------------------
  // Strobes between the groups
  //--------------------------------------------------------------------
  logic                   req;
  logic                   load_rd;
  logic [3:0]             load_sel;
  logic                   store_wr;

  // Register mode keeps the low byte only
  function automatic logic [9:0] lane(
    input logic [9:0] d,
    input logic       fifo
  );
    lane = fifo ? d : (d & sbi_pkg::BYTE_MASK);
  endfunction : lane

  // Chip select gates the strobe before anything else sees it
  assign req = BUS.bus_chip_select & BUS.transfer_strobe;

  //--------------------------------------------------------------------
  // Handshake sequencer
  //--------------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    wait_next  = wait_reg;
    ack_next   = 1'b0;
    wr_next    = wr_reg;
    sel_next   = sel_reg;
    load_rd    = 1'b0;
    load_sel   = sel_reg;
    store_wr   = 1'b0;
    case (state_reg)
      sbi_pkg::SBI_IDLE:
      begin
        if (req)
        begin
          wr_next   = BUS.write_not_read;
          sel_next  = BUS.register_select;
          wait_next = 8'(WAIT_CYCLES);
          // Read data is prepared before or with the ack
          load_rd   = 1'b1;
          load_sel  = BUS.register_select;
          if (WAIT_CYCLES == 0)
          begin
            ack_next   = 1'b1;
            state_next = sbi_pkg::SBI_ACK;
          end
          else
          begin
            state_next = sbi_pkg::SBI_WAIT;
          end
        end
      end
      sbi_pkg::SBI_WAIT:
      begin
        if (!req)
        begin
          state_next = sbi_pkg::SBI_IDLE;
        end
        else if (wait_reg <= sbi_pkg::WAIT_ONE)
        begin
          ack_next   = 1'b1;
          load_rd    = 1'b1;
          state_next = sbi_pkg::SBI_ACK;
        end
        else
        begin
          wait_next = wait_reg - sbi_pkg::WAIT_ONE;
        end
      end
      sbi_pkg::SBI_ACK:
      begin
        // Master terminates on the edge after it sees ack
        store_wr   = wr_reg;
        state_next = req ? sbi_pkg::SBI_DONE : sbi_pkg::SBI_IDLE;
      end
      sbi_pkg::SBI_DONE:
      begin
        // Strobe still high: no second ack in one strobe
        if (!req)
        begin
          state_next = sbi_pkg::SBI_IDLE;
        end
      end
      default:
      begin
        state_next = sbi_pkg::SBI_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      state_reg <= sbi_pkg::SBI_IDLE;
      wait_reg  <= sbi_pkg::WAIT_ZERO;
      ack_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      sel_reg   <= sbi_pkg::ADDR_ZERO;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg  <= wait_next;
      ack_reg   <= ack_next;
      wr_reg    <= wr_next;
      sel_reg   <= sel_next;
    end
  end

  //--------------------------------------------------------------------
  // Read data register
  //--------------------------------------------------------------------
  always_comb
  begin
    rdata_next = rdata_reg;
    if (load_rd)
    begin
      // Held until the next transfer loads it again
      rdata_next = lane(regs_reg[load_sel], FIFO_MODE_IN);
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rdata_reg <= sbi_pkg::DATA_ZERO;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  //--------------------------------------------------------------------
  // Register storage
  //--------------------------------------------------------------------
  always_comb
  begin
    regs_next = regs_reg;
    done_next = 1'b0;
    if (store_wr)
    begin
      regs_next[sel_reg] = lane(BUS.write_data_bus, FIFO_MODE_IN);
      done_next          = 1'b1;
    end
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      done_reg <= 1'b0;
      for (int i = 0; i < sbi_pkg::NUM_REGS; i++)
      begin
        regs_reg[i] <= sbi_pkg::DATA_ZERO;
      end
    end
    else
    begin
      done_reg <= done_next;
      regs_reg <= regs_next;
    end
  end

  //--------------------------------------------------------------------
  // Outputs, all straight from flops
  //--------------------------------------------------------------------
  assign BUS.transfer_ack  = ack_reg;
  assign BUS.read_data_bus = rdata_reg;
  assign REG_VIEW_OUT      = regs_reg;
  assign WRITE_DONE_OUT    = done_reg;
  assign WRITE_SEL_OUT     = sel_reg;
endmodule : sbi_slave
`default_nettype wire

// ==== pkg/sbi_pkg.sv ====
`default_nettype none
package sbi_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 10;
  localparam int BYTE_W = 8;
  localparam int NUM_REGS = 16;
  localparam logic [9:0] DATA_ZERO = 10'h000;
  localparam logic [9:0] BYTE_MASK = 10'h0ff;
  localparam logic [3:0] ADDR_ZERO = 4'h0;
  // Bus clock limit and our clock, in MHz
  localparam int BUS_MAX_MHZ = 133;
  localparam int CLK_MHZ = 100;
  // Default wait states before the slave acknowledges
  localparam int WAIT_STATES = 0;
  // Wait counter reset value, then its end point and step
  localparam logic [7:0] WAIT_ZERO = 8'h00;
  localparam logic [7:0] WAIT_ONE = 8'h01;
  typedef enum logic [1:0] {
    SBI_IDLE,
    SBI_WAIT,
    SBI_ACK,
    SBI_DONE
  } sbi_sl_state_t;
  typedef enum logic [1:0] {SBI_M_IDLE, SBI_M_REQ, SBI_M_END} sbi_ms_state_t;
endpackage : sbi_pkg
`default_nettype wire

// ==== pkg/sbi_if.sv ====
`default_nettype none
interface sbi_if;
  logic       bus_chip_select;
  logic       transfer_strobe;
  logic       write_not_read;
  logic [3:0] register_select;
  logic [9:0] write_data_bus;
  logic [9:0] read_data_bus;
  logic       transfer_ack;
  modport slave (
    input  bus_chip_select,
    input  transfer_strobe,
    input  write_not_read,
    input  register_select,
    input  write_data_bus,
    output read_data_bus,
    output transfer_ack
  );
  modport master (
    output bus_chip_select,
    output transfer_strobe,
    output write_not_read,
    output register_select,
    output write_data_bus,
    input  read_data_bus,
    input  transfer_ack
  );
endinterface : sbi_if
`default_nettype wire

// ==== logic/sbi_master.sv ====
`default_nettype none
module sbi_master (
  input  wire logic       CLK_IN,
  input  wire logic       RESETN_IN,
  sbi_if.master           BUS,
  input  wire logic       REQ_VALID_IN,
  input  wire logic       REQ_WRITE_IN,
  input  wire logic [3:0] REQ_SEL_IN,
  input  wire logic [9:0] REQ_DATA_IN,
  output logic            REQ_READY_OUT,
  output logic            RSP_VALID_OUT,
  output logic [9:0]      RSP_DATA_OUT
);
  //--------------------------------------------------------------------
  // Request sequencer
  //--------------------------------------------------------------------
  sbi_pkg::sbi_ms_state_t state_reg;
  sbi_pkg::sbi_ms_state_t state_next;
  logic       stb_reg;
  logic       stb_next;
  logic       wnr_reg;
  logic       wnr_next;
  logic [3:0] sel_reg;
  logic [3:0] sel_next;
  logic [9:0] wdat_reg;
  logic [9:0] wdat_next;
  logic       rv_reg;
  logic       rv_next;
  logic [9:0] rd_reg;
  logic [9:0] rd_next;
  logic       ready_reg;
  logic       ready_next;

  always_comb
  begin
    state_next = state_reg;
    stb_next   = stb_reg;
    wnr_next   = wnr_reg;
    sel_next   = sel_reg;
    wdat_next  = wdat_reg;
    rv_next    = 1'b0;
    rd_next    = rd_reg;
    case (state_reg)
      sbi_pkg::SBI_M_IDLE:
      begin
        if (REQ_VALID_IN)
        begin
          // All request signals change on one edge
          stb_next   = 1'b1;
          wnr_next   = REQ_WRITE_IN;
          sel_next   = REQ_SEL_IN;
          wdat_next  = REQ_DATA_IN;
          state_next = sbi_pkg::SBI_M_REQ;
        end
      end
      sbi_pkg::SBI_M_REQ:
      begin
        // Hold for any number of wait states
        if (BUS.transfer_ack)
        begin
          stb_next = 1'b0;
          wnr_next = 1'b0;
          if (!wnr_reg)
          begin
            rd_next = BUS.read_data_bus;
            rv_next = 1'b1;
          end
          state_next = sbi_pkg::SBI_M_END;
        end
      end
      sbi_pkg::SBI_M_END:
        state_next = sbi_pkg::SBI_M_IDLE;
      default:
        state_next = sbi_pkg::SBI_M_IDLE;
    endcase
    // Ready is registered so the output comes from a flop
    ready_next = (state_next == sbi_pkg::SBI_M_IDLE);
  end

  always_ff @(posedge CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      state_reg <= sbi_pkg::SBI_M_IDLE;
      stb_reg   <= 1'b0;
      wnr_reg   <= 1'b0;
      sel_reg   <= sbi_pkg::ADDR_ZERO;
      wdat_reg  <= sbi_pkg::DATA_ZERO;
      rv_reg    <= 1'b0;
      rd_reg    <= sbi_pkg::DATA_ZERO;
      ready_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      stb_reg   <= stb_next;
      wnr_reg   <= wnr_next;
      sel_reg   <= sel_next;
      wdat_reg  <= wdat_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
      ready_reg <= ready_next;
    end
  end

  // Single master: no arbiter needed in front of the slave
  assign BUS.bus_chip_select = stb_reg;
  assign BUS.transfer_strobe = stb_reg;
  assign BUS.write_not_read  = wnr_reg;
  assign BUS.register_select = sel_reg;
  assign BUS.write_data_bus  = wdat_reg;
  assign REQ_READY_OUT       = ready_reg;
  assign RSP_VALID_OUT       = rv_reg;
  assign RSP_DATA_OUT        = rd_reg;
endmodule : sbi_master
`default_nettype wire

// ==== tb/sbi_asserts.sv ====
`default_nettype none
module sbi_asserts (
  input wire logic       CLK_IN,
  input wire logic       RESETN_IN,
  input wire logic       bus_chip_select,
  input wire logic       transfer_strobe,
  input wire logic       write_not_read,
  input wire logic [3:0] register_select,
  input wire logic [9:0] write_data_bus,
  input wire logic [9:0] read_data_bus,
  input wire logic       transfer_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);
  sequence s_start;
    $rose(transfer_strobe) && bus_chip_select;
  endsequence
  sequence s_finish;
    transfer_ack ##1 (!transfer_ack && !transfer_strobe);
  endsequence
  chk_ack_follows: assert property (s_start |=> s_finish)
    else $error("ack did not follow strobe");
  chk_ack_gated: assert property (
    transfer_ack |-> bus_chip_select && transfer_strobe)
    else $error("ack without strobe");
  chk_ack_single: assert property (transfer_ack |=> !transfer_ack)
    else $error("ack longer than one cycle");
  chk_no_early: assert property (
    $rose(transfer_strobe) |-> !transfer_ack)
    else $error("ack in request cycle");
  chk_min_len: assert property (
    $rose(transfer_strobe) |=> transfer_strobe)
    else $error("transfer too short");
  chk_dir_drop: assert property (
    transfer_ack && write_not_read |=> !write_not_read)
    else $error("direction held after write");
  chk_req_hold: assert property (transfer_strobe && !transfer_ack |=>
    $stable(register_select) && $stable(write_data_bus))
    else $error("request changed before ack");
  chk_rd_hold: assert property (
    transfer_ack && !write_not_read |=> $stable(read_data_bus))
    else $error("read data moved after ack");
  chk_cs_with_stb: assert property (transfer_strobe |-> bus_chip_select)
    else $error("strobe without chip select");
endmodule : sbi_asserts
`default_nettype wire

// ==== tb/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, rstn = 1'b0, fifo = 1'b0;
  logic        req_valid = 1'b0, req_write = 1'b0;
  logic [3:0]  req_sel = 4'h0, wsel;
  logic [9:0]  req_data = 10'h000, rsp_data, exp_wire, model [16];
  logic [9:0]  view [sbi_pkg::NUM_REGS];
  logic        ready, rsp_valid, wdone;
  logic [31:0] seed = 32'hd00222dc, r;
  int          n_mismatch = 0, n_checks = 0, cyc = 0;
  sbi_if bus ();
  always #5 clk = ~clk;
  sbi_master sbi_master_inst (.CLK_IN(clk), .RESETN_IN(rstn), .BUS(bus),
    .REQ_VALID_IN(req_valid), .REQ_WRITE_IN(req_write),
    .REQ_SEL_IN(req_sel), .REQ_DATA_IN(req_data), .REQ_READY_OUT(ready),
    .RSP_VALID_OUT(rsp_valid), .RSP_DATA_OUT(rsp_data));
  sbi_slave sbi_slave_inst (.CLK_IN(clk), .RESETN_IN(rstn), .BUS(bus),
    .FIFO_MODE_IN(fifo), .REG_VIEW_OUT(view), .WRITE_DONE_OUT(wdone),
    .WRITE_SEL_OUT(wsel));
  sbi_asserts sbi_asserts_inst (.CLK_IN(clk), .RESETN_IN(rstn),
    .bus_chip_select(bus.bus_chip_select),
    .transfer_strobe(bus.transfer_strobe),
    .write_not_read(bus.write_not_read),
    .register_select(bus.register_select),
    .write_data_bus(bus.write_data_bus),
    .read_data_bus(bus.read_data_bus), .transfer_ack(bus.transfer_ack));
  task check(input logic [9:0] seen, input logic [9:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function logic [9:0] fit(input logic [9:0] d);
    return fifo ? d : d & sbi_pkg::BYTE_MASK;
  endfunction : fit
  task results();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : results
  task xfer(input logic w, input logic [3:0] s, input logic [9:0] d);
    int n;
    n = 0;
    @(posedge clk);
    exp_wire = w ? d : fit(model[s]);
    req_valid <= 1'b1;
    req_write <= w;
    req_sel <= s;
    req_data <= d;
    @(negedge clk);
    while (ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    while ((w ? wdone : rsp_valid) !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 50)
      n_mismatch++;
    if (w)
      model[s] = fit(d);
    if (w)
      check(view[s], model[s]);
    if (w)
      check({6'h00, wsel}, {6'h00, s});
    if (!w)
      check(rsp_data, fit(model[s]));
  endtask : xfer
  // Wire value seen with each ack
  always @(negedge clk)
    if (bus.transfer_ack === 1'b1)
      check(bus.write_not_read ? bus.write_data_bus : bus.read_data_bus,
        exp_wire);
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    for (int i = 0; i < 16; i++)
      model[i] = 10'h000;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    for (int i = 0; i < 16; i++)
      check(view[i], 10'h000);
    for (int i = 0; i < 16; i++)
      xfer(1'b1, 4'(i), 10'(rnd()));
    for (int i = 0; i < 16; i++)
      xfer(1'b0, 4'(i), 10'h000);
    $display("register mode test done");
    @(posedge clk);
    fifo <= 1'b1;
    xfer(1'b1, 4'hf, 10'h3ff);
    xfer(1'b0, 4'hf, 10'h000);
    for (int i = 0; i < 40; i++)
    begin
      r = rnd();
      xfer(r[16], r[3:0], r[13:4]);
    end
    $display("fifo mode test done");
    @(posedge clk);
    fifo <= 1'b0;
    xfer(1'b0, 4'hf, 10'h000);
    $display("mode switch test done");
    results();
  end
endmodule : testbench
`default_nettype wire
